// [sp2_regs.vh]
// Register addresses, field positions, reset values and counts for the second serial port
`ifndef SP2_REGS_VH
`define SP2_REGS_VH

// Register addresses on the special function register bus
`define SP2_A_CTRL      8'hc0
`define SP2_A_BUF       8'hc1
`define SP2_A_ADDR      8'haa
`define SP2_A_MASK      8'hba
`define SP2_A_RELOAD    8'h9a
`define SP2_A_BDR0      8'h9b
`define SP2_A_BDR1      8'h9c
`define SP2_A_AUX       8'h8e

// Reset values
`define SP2_RST_BYTE    8'h00

// Control/status field positions
`define SP2_B_SM0FE     7
`define SP2_B_SM1       6
`define SP2_B_SM2       5
`define SP2_B_REN       4
`define SP2_B_TB8       3
`define SP2_B_RB8       2
`define SP2_B_TI        1
`define SP2_B_RI        0

// Baud generator control field positions
`define SP2_B_BRR       4
`define SP2_B_TBCK      3
`define SP2_B_RBCK      2
`define SP2_B_SPD       1

// Auxiliary configuration: pin position select
`define SP2_B_PINSEL    2

// Timing counts
`define SP2_OVS_LAST    4'hf
`define SP2_OVS_MID     4'h7
`define SP2_SLOW_LAST   3'h5
`define SP2_BRG_TOP     8'hff
`define SP2_BITS_TEN    4'ha
`define SP2_BITS_ELEVEN 4'hb
`define SP2_RX_LAST8    4'h7
`define SP2_RX_LAST9    4'h8

// Receive buffer entry: frame error, ninth bit, data
`define SP2_ENTRY_W     10

`endif

// [sp2_fifo2.v]
// Two-entry valid/ready buffer between the receive shifter and the holding register
`timescale 1ns/1ps
`include "sp2_regs.vh"

module sp2_fifo2 (
  // Clock and reset
  input  wire                      clk,
  input  wire                      reset_n,
  // Filling side
  input  wire                      inValid,
  output wire                      inReady,
  input  wire [`SP2_ENTRY_W-1:0]   inData,
  // Draining side
  output wire                      outValid,
  input  wire                      outReady,
  output wire [`SP2_ENTRY_W-1:0]   outData
);

  reg [`SP2_ENTRY_W-1:0] mem_r [0:1];
  reg                    wrPtr_r;
  reg                    rdPtr_r;
  reg [1:0]              count_r;
  wire                   push;
  wire                   pop;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_r[0] <= {`SP2_ENTRY_W{1'b0}};
      mem_r[1] <= {`SP2_ENTRY_W{1'b0}};
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wrPtr_r] <= inData;
        wrPtr_r        <= ~wrPtr_r;
      end
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      if (push && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push)
        count_r <= count_r - 2'h1;
    end
  end

endmodule

// [sp2_uart.v]
// Second asynchronous serial port with shared baud rate generator
`timescale 1ns/1ps
`include "sp2_regs.vh"

module sp2_uart (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Special function register bus
  input  wire [7:0] sfrAddr,
  input  wire       sfrWrEn,
  input  wire [7:0] sfrWrData,
  input  wire       sfrRdEn,
  output reg  [7:0] sfrRdData_r,
  output reg        sfrRdHit_r,
  // Power and mode controls
  input  wire       powerDown,
  input  wire       frameErrSel,
  // Baud sources
  input  wire       timerOvf,
  output reg        brgTickFirst_r,
  // Port 1 alternate pins
  input  wire       rxPinPos2,
  input  wire       rxPinPos6,
  output reg        txPinPos3_r,
  output reg        txPinPos7_r,
  // Interrupt request
  output reg        intReq_r
);

  localparam [3:0] RX_IDLE  = 4'h1;
  localparam [3:0] RX_START = 4'h2;
  localparam [3:0] RX_DATA  = 4'h4;
  localparam [3:0] RX_STOP  = 4'h8;

  // Register file
  reg  [7:0] stationAddr_r;
  reg  [7:0] stationMask_r;
  reg  [7:0] baudReload_r;
  reg  [7:0] bdrFirst_r;
  reg  [7:0] bdrSecond_r;
  reg        pinSel_r;
  reg        sm0_r;
  reg        sm1_r;
  reg        sm2_r;
  reg        rxEnable_r;
  reg        txNinth_r;
  reg        rxNinth_r;
  reg        txDone_r;
  reg        rxDone_r;
  reg        frameErr_r;
  reg  [7:0] rxHold_r;
  // Baud generator
  reg  [7:0] brgCnt_r;
  reg  [2:0] brgPre_r;
  reg        brgTick_r;
  reg        fixedTick_r;
  // Transmitter
  reg [10:0] txShift_r;
  reg  [3:0] txLeft_r;
  reg  [3:0] txOvs_r;
  // Receiver
  reg  [3:0] rxState_r;
  reg  [3:0] rxOvs_r;
  reg  [3:0] rxIdx_r;
  reg  [8:0] rxShift_r;
  reg        rxIn_r;
  reg        rxPrev_r;
  reg        pushValid_r;
  reg [`SP2_ENTRY_W-1:0] pushData_r;

  wire       run;
  wire       nineBit;
  wire       txTick;
  wire       rxTick;
  wire       wrCtrl;
  wire       wrBuf;
  wire       fifoInReady;
  wire       fifoOutValid;
  wire [`SP2_ENTRY_W-1:0] fifoOut;
  wire       drain;
  wire       rxSample;
  wire       stopBit;
  wire [7:0] rxData;
  wire       rxNinthIn;
  wire [7:0] bcast;
  wire       addrOk;
  wire       accept;

  // Bits that are set in the care mask are compared; cleared ones are ignored
  function maskedMatch;
    input [7:0] data;
    input [7:0] refVal;
    input [7:0] care;
    begin
      maskedMatch = (((data ^ refVal) & care) == 8'h00);
    end
  endfunction

  // Power-down stops the baud generator, transmitter and receiver; register access and intReq_r keep running
  assign run     = ~powerDown;
  assign nineBit = sm0_r;
  assign wrCtrl  = sfrWrEn && (sfrAddr == `SP2_A_CTRL);
  assign wrBuf   = sfrWrEn && (sfrAddr == `SP2_A_BUF);

  // Mode 2 runs from a fixed divider; modes 1 and 3 from the selected timer
  assign txTick = nineBit && !sm1_r ? fixedTick_r :
                  (bdrSecond_r[`SP2_B_TBCK] ? brgTick_r : timerOvf);
  assign rxTick = nineBit && !sm1_r ? fixedTick_r :
                  (bdrSecond_r[`SP2_B_RBCK] ? brgTick_r : timerOvf);

  // Register writes; hardware sets of the flags win over software clears
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stationAddr_r <= `SP2_RST_BYTE;
      stationMask_r <= `SP2_RST_BYTE;
      baudReload_r  <= `SP2_RST_BYTE;
      bdrFirst_r    <= `SP2_RST_BYTE;
      bdrSecond_r   <= `SP2_RST_BYTE;
      pinSel_r      <= 1'b0;
      sm0_r         <= 1'b0;
      sm1_r         <= 1'b0;
      sm2_r         <= 1'b0;
      rxEnable_r    <= 1'b0;
      txNinth_r     <= 1'b0;
      rxNinth_r     <= 1'b0;
      txDone_r      <= 1'b0;
      rxDone_r      <= 1'b0;
      frameErr_r    <= 1'b0;
      rxHold_r      <= `SP2_RST_BYTE;
    end else begin
      if (sfrWrEn) begin
        case (sfrAddr)
          `SP2_A_ADDR:   stationAddr_r <= sfrWrData;
          `SP2_A_MASK:   stationMask_r <= sfrWrData;
          `SP2_A_RELOAD: baudReload_r  <= sfrWrData;
          `SP2_A_BDR0:   bdrFirst_r    <= sfrWrData;
          `SP2_A_BDR1:   bdrSecond_r   <= sfrWrData;
          `SP2_A_AUX:    pinSel_r      <= sfrWrData[`SP2_B_PINSEL];
          default: begin
          end
        endcase
      end
      if (wrCtrl) begin
        if (frameErrSel)
          frameErr_r <= sfrWrData[`SP2_B_SM0FE];
        else
          sm0_r <= sfrWrData[`SP2_B_SM0FE];
        sm1_r      <= sfrWrData[`SP2_B_SM1];
        sm2_r      <= sfrWrData[`SP2_B_SM2];
        rxEnable_r <= sfrWrData[`SP2_B_REN];
        txNinth_r  <= sfrWrData[`SP2_B_TB8];
        rxNinth_r  <= sfrWrData[`SP2_B_RB8];
        txDone_r   <= sfrWrData[`SP2_B_TI];
        rxDone_r   <= sfrWrData[`SP2_B_RI];
      end
      if (run && txLeft_r == 4'h1 && txTick && txOvs_r == `SP2_OVS_LAST)
        txDone_r <= 1'b1;
      if (drain) begin
        rxHold_r  <= fifoOut[7:0];
        rxNinth_r <= fifoOut[8];
        rxDone_r  <= 1'b1;
        if (fifoOut[9])
          frameErr_r <= 1'b1;
      end
    end
  end

  // Register reads: data stands one cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData_r <= `SP2_RST_BYTE;
      sfrRdHit_r  <= 1'b0;
    end else begin
      sfrRdHit_r <= 1'b0;
      if (sfrRdEn) begin
        sfrRdHit_r <= 1'b1;
        case (sfrAddr)
          `SP2_A_CTRL:   sfrRdData_r <= {frameErrSel ? frameErr_r : sm0_r, sm1_r, sm2_r,
                                         rxEnable_r, txNinth_r, rxNinth_r, txDone_r, rxDone_r};
          `SP2_A_BUF:    sfrRdData_r <= rxHold_r;
          `SP2_A_ADDR:   sfrRdData_r <= stationAddr_r;
          `SP2_A_MASK:   sfrRdData_r <= stationMask_r;
          `SP2_A_RELOAD: sfrRdData_r <= baudReload_r;
          `SP2_A_BDR0:   sfrRdData_r <= bdrFirst_r;
          `SP2_A_BDR1:   sfrRdData_r <= bdrSecond_r;
          default: begin
            sfrRdData_r <= `SP2_RST_BYTE;
            sfrRdHit_r  <= 1'b0;
          end
        endcase
      end
    end
  end

  // Shared baud generator: counts up from the reload value, ticks on overflow
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brgCnt_r       <= `SP2_RST_BYTE;
      brgPre_r       <= 3'h0;
      brgTick_r      <= 1'b0;
      brgTickFirst_r <= 1'b0;
      fixedTick_r    <= 1'b0;
    end else begin
      brgTick_r      <= 1'b0;
      brgTickFirst_r <= 1'b0;
      if (run) begin
        fixedTick_r <= ~fixedTick_r;
        if (bdrFirst_r[`SP2_B_BRR]) begin
          // Slow speed divides by six, trading resolution for range
          if (bdrFirst_r[`SP2_B_SPD] || brgPre_r == `SP2_SLOW_LAST) begin
            brgPre_r <= 3'h0;
            if (brgCnt_r == `SP2_BRG_TOP) begin
              brgCnt_r       <= baudReload_r;
              brgTick_r      <= 1'b1;
              brgTickFirst_r <= 1'b1;
            end else begin
              brgCnt_r <= brgCnt_r + 8'h01;
            end
          end else begin
            brgPre_r <= brgPre_r + 3'h1;
          end
        end else begin
          brgCnt_r <= baudReload_r;
          brgPre_r <= 3'h0;
        end
      end
    end
  end

  // Transmitter: a buffer write loads the frame and starts sending
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txShift_r   <= 11'h7ff;
      txLeft_r    <= 4'h0;
      txOvs_r     <= 4'h0;
      txPinPos3_r <= 1'b1;
      txPinPos7_r <= 1'b1;
    end else if (run) begin
      if (wrBuf) begin
        // Mode 1 places a stop bit where the ninth bit would be
        txShift_r <= {1'b1, nineBit ? txNinth_r : 1'b1, sfrWrData, 1'b0};
        txLeft_r  <= nineBit ? `SP2_BITS_ELEVEN : `SP2_BITS_TEN;
        txOvs_r   <= 4'h0;
      end else if (txLeft_r != 4'h0 && txTick) begin
        txOvs_r <= txOvs_r + 4'h1;
        if (txOvs_r == `SP2_OVS_LAST) begin
          txShift_r <= {1'b1, txShift_r[10:1]};
          txLeft_r  <= txLeft_r - 4'h1;
        end
      end
      txPinPos3_r <= pinSel_r | (txLeft_r == 4'h0) | txShift_r[0];
      txPinPos7_r <= ~pinSel_r | (txLeft_r == 4'h0) | txShift_r[0];
    end
  end

  // Receiver datapath decoding
  assign rxSample  = rxTick && rxOvs_r == `SP2_OVS_MID;
  assign stopBit   = rxIn_r;
  assign rxData    = nineBit ? rxShift_r[7:0] : rxShift_r[8:1];
  assign rxNinthIn = nineBit ? rxShift_r[8] : stopBit;
  assign bcast     = stationAddr_r | stationMask_r;
  assign addrOk    = maskedMatch(rxData, stationAddr_r, stationMask_r) |
                     maskedMatch(rxData, bcast, bcast);
  // Mode 1 with the multiprocessor bit keeps only frames with a valid stop bit
  assign accept    = !sm2_r || (nineBit ? (rxNinthIn && addrOk) : stopBit);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState_r   <= RX_IDLE;
      rxOvs_r     <= 4'h0;
      rxIdx_r     <= 4'h0;
      rxShift_r   <= 9'h000;
      rxIn_r      <= 1'b1;
      rxPrev_r    <= 1'b1;
      pushValid_r <= 1'b0;
      pushData_r  <= {`SP2_ENTRY_W{1'b0}};
    end else if (run) begin
      rxIn_r   <= pinSel_r ? rxPinPos6 : rxPinPos2;
      rxPrev_r <= rxIn_r;
      if (pushValid_r && fifoInReady)
        pushValid_r <= 1'b0;
      if (rxTick && rxState_r != RX_IDLE)
        rxOvs_r <= rxOvs_r + 4'h1;
      case (rxState_r)
        RX_IDLE: begin
          // A new start is only taken while the buffer has room, so no word is overwritten
          if (rxEnable_r && fifoInReady && !pushValid_r && rxPrev_r && !rxIn_r) begin
            rxState_r <= RX_START;
            rxOvs_r   <= 4'h0;
          end
        end
        RX_START: begin
          if (rxSample) begin
            rxIdx_r <= 4'h0;
            rxState_r <= rxIn_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSample) begin
            rxShift_r <= {rxIn_r, rxShift_r[8:1]};
            rxIdx_r   <= rxIdx_r + 4'h1;
            if (rxIdx_r == (nineBit ? `SP2_RX_LAST9 : `SP2_RX_LAST8))
              rxState_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxSample) begin
            rxState_r <= RX_IDLE;
            if (accept) begin
              pushValid_r <= 1'b1;
              pushData_r  <= {~stopBit, rxNinthIn, rxData};
            end
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // Holding register takes the next word once software has cleared the receive flag
  assign drain = run && fifoOutValid && !rxDone_r;

  sp2_fifo2 u_rxBuf (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (pushValid_r & run),
    .inReady  (fifoInReady),
    .inData   (pushData_r),
    .outValid (fifoOutValid),
    .outReady (~rxDone_r & run),
    .outData  (fifoOut)
  );

  // Priority against timer 2 is resolved in the interrupt controller; this is the raw request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      intReq_r <= 1'b0;
    else
      intReq_r <= txDone_r | rxDone_r;
  end

endmodule

// [sp2_assertions.sv]
// Port-level assertions for the second serial port
`timescale 1ns/1ps
`include "sp2_regs.vh"
module sp2_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Register bus
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData_r,
  input wire logic       sfrRdHit_r,
  // Controls, pins and request
  input wire logic       powerDown,
  input wire logic       frameErrSel,
  input wire logic       timerOvf,
  input wire logic       brgTickFirst_r,
  input wire logic       rxPinPos2,
  input wire logic       rxPinPos6,
  input wire logic       txPinPos3_r,
  input wire logic       txPinPos7_r,
  input wire logic       intReq_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire owned = sfrAddr inside {8'hc0, 8'hc1, 8'haa, 8'hba, 8'h9a, 8'h9b, 8'h9c};

  a_read_owned: assert property (sfrRdEn && owned |=> sfrRdHit_r)
    else $error("owned read without hit");
  a_read_unmapped: assert property (sfrRdEn && !owned |=> !sfrRdHit_r && sfrRdData_r == 8'h00)
    else $error("unmapped read answered");
  a_hit_pulse: assert property (!sfrRdEn |=> !sfrRdHit_r)
    else $error("hit without read");
  a_data_hold: assert property (!sfrRdEn |=> $stable(sfrRdData_r))
    else $error("read data moved between reads");
  a_addr_readback: assert property (sfrWrEn && sfrAddr == `SP2_A_ADDR ##1 !sfrWrEn
    ##1 sfrRdEn && sfrAddr == `SP2_A_ADDR |=> sfrRdData_r == $past(sfrWrData, 3))
    else $error("station address readback differs");
  a_flag_irq: assert property (sfrRdEn && sfrAddr == `SP2_A_CTRL |=> intReq_r == |sfrRdData_r[1:0])
    else $error("request disagrees with flags");
  a_unsel_high: assert property (txPinPos3_r || txPinPos7_r)
    else $error("both transmit positions low");
  a_pd_freeze: assert property (powerDown |=> $stable(txPinPos3_r) && $stable(txPinPos7_r))
    else $error("transmit pin moved in power-down");

  c_buf_write: cover property (sfrWrEn && sfrAddr == `SP2_A_BUF);
  c_irq_rise: cover property ($rose(intReq_r));
  c_pd_low: cover property (powerDown && !txPinPos7_r);
endmodule

bind sp2_uart sp2_assertions u_sp2_assertions (.clk(clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
  .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData_r(sfrRdData_r),
  .sfrRdHit_r(sfrRdHit_r), .powerDown(powerDown), .frameErrSel(frameErrSel), .timerOvf(timerOvf),
  .brgTickFirst_r(brgTickFirst_r), .rxPinPos2(rxPinPos2), .rxPinPos6(rxPinPos6),
  .txPinPos3_r(txPinPos3_r), .txPinPos7_r(txPinPos7_r), .intReq_r(intReq_r));

// [sp2_partner.sv]
// Remote serial station on the far side of the second port
`timescale 1ns/1ps
module sp2_partner #(
  parameter int BIT_CYC = 32
) (
  // Clock
  input  wire logic clk,
  // Line from and to the port
  input  wire logic lineIn,
  output logic      lineOut
);
  logic       nineMode = 1'b0;
  logic [7:0] gotData;
  logic       gotNine;
  logic       gotStop;
  int         gotCnt = 0;
  logic [9:0] sh;

  // Pulled-up line rests high
  initial lineOut = 1'b1;

  task automatic send(input logic [7:0] d, input logic n9, input logic use9, input logic stp);
    logic [10:0] f;
    f = use9 ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (use9 ? 11 : 10); i++) begin
      @(posedge clk) lineOut <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk) lineOut <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask

  // Samples mid-bit; ninth bit only when told the port sends nine
  always begin
    @(negedge lineIn);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int j = 0; j < (nineMode ? 10 : 9); j++) begin
      repeat (BIT_CYC) @(posedge clk);
      sh[j] = lineIn;
    end
    gotData = sh[7:0];
    gotNine = sh[8];
    gotStop = nineMode ? sh[9] : sh[8];
    gotCnt++;
  end
endmodule

// [sp2_uart_bench.sv]
// Self-checking bench for the second serial port
`timescale 1ns/1ps
`include "sp2_regs.vh"
module sp2_uart_bench;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic       sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic       sfrRdEn = 1'b0;
  logic       powerDown = 1'b0;
  logic       frameErrSel = 1'b0;
  logic       timerOvf = 1'b0;
  logic       ovfOn = 1'b1;
  logic       posSel = 1'b0;
  wire  [7:0] sfrRdData_r;
  wire        sfrRdHit_r;
  wire        brgTickFirst_r;
  wire        txPinPos3_r;
  wire        txPinPos7_r;
  wire        intReq_r;
  wire        line;
  wire        rxPinPos2 = posSel ? 1'b1 : line;
  wire        rxPinPos6 = posSel ? line : 1'b1;
  int         errCount = 0;
  int         nCompared = 0;
  int         cyc = 0;
  logic [7:0] v;

  always #5 clk = ~clk;
  // A tick every second clock gives 32 clocks per bit
  // Ticks can be stopped so that generator and fixed-tick scenarios prove their own source
  always @(posedge clk) timerOvf <= ovfOn & ~timerOvf;

  sp2_uart u_sp2_uart (.clk(clk), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData_r(sfrRdData_r), .sfrRdHit_r(sfrRdHit_r),
    .powerDown(powerDown), .frameErrSel(frameErrSel), .timerOvf(timerOvf),
    .brgTickFirst_r(brgTickFirst_r), .rxPinPos2(rxPinPos2), .rxPinPos6(rxPinPos6),
    .txPinPos3_r(txPinPos3_r), .txPinPos7_r(txPinPos7_r), .intReq_r(intReq_r));
  sp2_partner #(.BIT_CYC(32)) u_sp2_partner (.clk(clk), .lineIn(posSel ? txPinPos7_r : txPinPos3_r),
    .lineOut(line));

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    #1 v = sfrRdData_r;
  endtask

  // Polls control until all flags in m are up; the cycle ceiling bounds it
  task waitFlags(input logic [7:0] m);
    rd(`SP2_A_CTRL);
    while ((v & m) !== m) rd(`SP2_A_CTRL);
  endtask

  task t_regs;
    logic [7:0] ra [4];
    ra = '{`SP2_A_CTRL, `SP2_A_ADDR, `SP2_A_MASK, `SP2_A_RELOAD};
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk(v, `SP2_RST_BYTE);
    end
    rd(8'h55);
    chk({7'h00, sfrRdHit_r}, 8'h00);
    wr(`SP2_A_ADDR, 8'h12);
    rd(`SP2_A_ADDR);
    chk(v, 8'h12);
    wr(`SP2_A_MASK, 8'hff);
    rd(`SP2_A_MASK);
    chk(v, 8'hff);
  endtask

  task t_duplex;
    wr(`SP2_A_CTRL, 8'h50);
    fork
      u_sp2_partner.send(8'h3c, 1'b0, 1'b0, 1'b1);
      wr(`SP2_A_BUF, 8'ha5);
    join
    waitFlags(8'h03);
    chk(v, 8'h57);
    chk({7'h00, intReq_r}, 8'h01);
    chk(u_sp2_partner.gotData, 8'ha5);
    chk({7'h00, u_sp2_partner.gotStop}, 8'h01);
    rd(`SP2_A_BUF);
    chk(v, 8'h3c);
  endtask

  task t_double;
    wr(`SP2_A_CTRL, 8'h50);
    u_sp2_partner.send(8'h11, 1'b0, 1'b0, 1'b1);
    u_sp2_partner.send(8'h22, 1'b0, 1'b0, 1'b1);
    rd(`SP2_A_BUF);
    chk(v, 8'h11);
    wr(`SP2_A_CTRL, 8'h50);
    waitFlags(8'h01);
    rd(`SP2_A_BUF);
    chk(v, 8'h22);
  endtask

  task t_ferr;
    wr(`SP2_A_CTRL, 8'h50);
    frameErrSel <= 1'b1;
    u_sp2_partner.send(8'h5a, 1'b0, 1'b0, 1'b0);
    waitFlags(8'h01);
    chk(v, 8'hd1);
    @(posedge clk) frameErrSel <= 1'b0;
  endtask

  task t_ninth;
    int n;
    n = u_sp2_partner.gotCnt;
    u_sp2_partner.nineMode = 1'b1;
    wr(`SP2_A_CTRL, 8'hd8);
    wr(`SP2_A_BUF, 8'h81);
    #1 chk({7'h00, intReq_r}, 8'h00);
    waitFlags(8'h02);
    chk(8'(u_sp2_partner.gotCnt - n), 8'h01);
    chk(u_sp2_partner.gotData, 8'h81);
    chk({7'h00, u_sp2_partner.gotNine}, 8'h01);
    u_sp2_partner.nineMode = 1'b0;
  endtask

  task t_filter;
    wr(`SP2_A_CTRL, 8'hf0);
    u_sp2_partner.send(8'h34, 1'b1, 1'b1, 1'b1);
    u_sp2_partner.send(8'h12, 1'b0, 1'b1, 1'b1);
    u_sp2_partner.send(8'h12, 1'b1, 1'b1, 1'b1);
    waitFlags(8'h01);
    chk(v, 8'hf5);
    rd(`SP2_A_BUF);
    chk(v, 8'h12);
    wr(`SP2_A_CTRL, 8'hf0);
    u_sp2_partner.send(8'hff, 1'b1, 1'b1, 1'b1);
    waitFlags(8'h01);
    rd(`SP2_A_BUF);
    chk(v, 8'hff);
    wr(`SP2_A_CTRL, 8'hd0);
    u_sp2_partner.send(8'h34, 1'b0, 1'b1, 1'b1);
    waitFlags(8'h01);
    rd(`SP2_A_BUF);
    chk(v, 8'h34);
  endtask

  task t_brg;
    int k;
    wr(`SP2_A_RELOAD, 8'hfc);
    wr(`SP2_A_BDR0, 8'h12);
    k = 0;
    while (brgTickFirst_r !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1 k++;
    end
    chk({7'h00, brgTickFirst_r}, 8'h01);
    // Reload 0xfc overflows every fourth clock at full speed
    repeat (3) @(posedge clk);
    #1 chk({7'h00, brgTickFirst_r}, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, brgTickFirst_r}, 8'h01);
    // Reload 0xfe gives a tick every second clock, the same bit time as the timer
    wr(`SP2_A_RELOAD, 8'hfe);
    wr(`SP2_A_BDR1, 8'h0c);
    ovfOn <= 1'b0;
    wr(`SP2_A_CTRL, 8'h50);
    fork
      u_sp2_partner.send(8'h96, 1'b0, 1'b0, 1'b1);
      wr(`SP2_A_BUF, 8'hc3);
    join
    waitFlags(8'h03);
    chk(u_sp2_partner.gotData, 8'hc3);
    rd(`SP2_A_BUF);
    chk(v, 8'h96);
    wr(`SP2_A_BDR1, 8'h00);
  endtask

  task t_fixed;
    u_sp2_partner.nineMode = 1'b1;
    wr(`SP2_A_CTRL, 8'h90);
    wr(`SP2_A_BUF, 8'h5e);
    waitFlags(8'h02);
    chk(u_sp2_partner.gotData, 8'h5e);
    chk({7'h00, u_sp2_partner.gotNine}, 8'h00);
    u_sp2_partner.nineMode = 1'b0;
    ovfOn <= 1'b1;
  endtask

  task t_pins;
    wr(`SP2_A_AUX, 8'h04);
    @(posedge clk) posSel <= 1'b1;
    wr(`SP2_A_CTRL, 8'h50);
    fork
      u_sp2_partner.send(8'h4d, 1'b0, 1'b0, 1'b1);
      wr(`SP2_A_BUF, 8'h6b);
    join
    waitFlags(8'h03);
    chk(u_sp2_partner.gotData, 8'h6b);
    rd(`SP2_A_BUF);
    chk(v, 8'h4d);
  endtask

  task t_pdown;
    wr(`SP2_A_CTRL, 8'h50);
    wr(`SP2_A_BUF, 8'h00);
    repeat (40) @(posedge clk);
    powerDown <= 1'b1;
    @(posedge clk);
    #1 chk({6'h00, txPinPos7_r, txPinPos3_r}, 8'h01);
    repeat (200) @(posedge clk);
    #1 chk({6'h00, txPinPos7_r, txPinPos3_r}, 8'h01);
    @(posedge clk) powerDown <= 1'b0;
    waitFlags(8'h02);
  endtask

  task print_verdict;
    if (errCount == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errCount++;
      print_verdict;
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_duplex;
    t_double;
    t_ferr;
    t_ninth;
    t_filter;
    t_brg;
    t_fixed;
    t_pins;
    t_pdown;
    print_verdict;
  end
endmodule
